/* File: hdl/beep_blink_seq.v */
// Purpose: Turns self-test events into speaker tones and LED blinks.
// Assumes: Event inputs are one-cycle pulses from logic on clk_sys.
// Notes: All pattern timing runs in 0.25 s steps from one divider.
// Notes on behaviour
// - Error events play matching tone and blink
// - Prompt: one 0.5 s 932 Hz tone
// - Video tones: two beeps, pause, twice only
// - Video error only without video option ROM
// - Memory tones: three beeps, pause, forever
// - Thermal: eight alternating tones, then shutdown
// - Update: silent, LED off, 0.5 s blinking
// - Video LED: two blinks, pause, forever
// - Memory LED: three blinks, pause, forever
// - Thermal LED: two quarter blinks per tone
`timescale 1ns/10ps
`default_nettype none
`include "beep_consts.vh"
module beep_blink_seq #(
    parameter integer CLK_HZ = `CLK_HZ,
    parameter integer QUARTER_CYC = CLK_HZ / `MS_PER_S * `QUARTER_MS
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire ev_prompt,
    input wire ev_update_start,
    input wire ev_update_done,
    input wire ev_video_err,
    input wire video_rom_found,
    input wire ev_mem_err,
    input wire ev_thermal,
    output reg tone_en_q,
    output reg [1:0] pitch_q,
    output wire spk_q,
    output reg led_q,
    output reg shutdown_q
);
    // Divider end point, cut to the divider width on purpose
    localparam [23:0] QUARTER_LAST = QUARTER_CYC[23:0] - 24'h000001;

    reg [2:0] mode_q;
    reg [5:0] pos_q;
    reg [1:0] grp_q;
    reg [23:0] qdiv_q;
    reg tick;
    reg start;
    reg [2:0] new_mode;
    reg done_acc;
    reg tone_d;
    reg [1:0] pitch_d;
    reg led_d;
    reg [5:0] grp_end;
    reg beat_on;
    reg video_burst;
    reg mem_burst;
    reg video_audible;
    reg therm_high;
    reg therm_lit;
    reg update_lit;

    // Event selection, most severe first
    always @* begin
        start = 1'b1;
        new_mode = `MODE_IDLE;
        if (ev_thermal) begin
            new_mode = `MODE_THERM;
        end else if (ev_mem_err) begin
            new_mode = `MODE_MEM;
        end else if (ev_video_err && !video_rom_found) begin
            new_mode = `MODE_VIDEO;
        end else if (ev_update_start) begin
            new_mode = `MODE_UPDATE;
        end else if (ev_prompt) begin
            new_mode = `MODE_PROMPT;
        end else begin
            start = 1'b0;
        end
        done_acc = ev_update_done && !start &&
                   (mode_q == `MODE_UPDATE);
    end

    always @* begin
        tick = (qdiv_q == QUARTER_LAST);
        case (mode_q)
            `MODE_PROMPT: grp_end = `PROMPT_END;
            `MODE_UPDATE: grp_end = `UPDATE_END;
            `MODE_VIDEO: grp_end = `VIDEO_END;
            `MODE_MEM: grp_end = `MEM_END;
            `MODE_THERM: grp_end = `THERM_END;
            default: grp_end = 6'h00;
        endcase
    end

    // Phase flags of the quarter-step position
    always @* begin
        beat_on = !pos_q[`BEAT_BIT];
        video_burst = (pos_q < `VIDEO_ON_END) && beat_on;
        mem_burst = (pos_q < `MEM_ON_END) && beat_on;
        video_audible = (grp_q < `VIDEO_TONE_GRPS);
        therm_high = !pos_q[`TONE_BIT];
        therm_lit = !pos_q[`QTR_BIT];
        update_lit = pos_q[`HALF_BIT];
    end

    // Output patterns from mode and position
    always @* begin
        tone_d = 1'b0;
        pitch_d = `PITCH_STD;
        led_d = led_q;
        case (mode_q)
            `MODE_PROMPT: begin
                tone_d = 1'b1;
            end
            `MODE_UPDATE: begin
                led_d = update_lit;
            end
            `MODE_VIDEO: begin
                tone_d = video_burst && video_audible;
                led_d = video_burst;
            end
            `MODE_MEM: begin
                tone_d = mem_burst;
                led_d = mem_burst;
            end
            `MODE_THERM: begin
                tone_d = 1'b1;
                pitch_d = therm_high ? `PITCH_HIGH : `PITCH_LOW;
                led_d = therm_lit;
            end
            `MODE_HALT: begin
                led_d = 1'b0;
            end
            default: begin
                tone_d = 1'b0;
            end
        endcase
    end

    // Sequencer state
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_q <= `MODE_IDLE;
            pos_q <= 6'h00;
            grp_q <= 2'h0;
            qdiv_q <= 24'h000000;
            shutdown_q <= 1'b0;
        end else if (start) begin
            // Restart timing so the first step is a full quarter
            mode_q <= new_mode;
            pos_q <= 6'h00;
            grp_q <= 2'h0;
            qdiv_q <= 24'h000000;
        end else if (done_acc) begin
            mode_q <= `MODE_IDLE;
            pos_q <= 6'h00;
            qdiv_q <= 24'h000000;
        end else begin
            qdiv_q <= tick ? 24'h000000 : qdiv_q + 24'h000001;
            if (tick && (mode_q != `MODE_IDLE) &&
                (mode_q != `MODE_HALT)) begin
                if (pos_q != grp_end) begin
                    pos_q <= pos_q + 6'h01;
                end else begin
                    pos_q <= 6'h00;
                    case (mode_q)
                        `MODE_PROMPT: mode_q <= `MODE_IDLE;
                        `MODE_THERM: begin
                            mode_q <= `MODE_HALT;
                            shutdown_q <= 1'b1;
                        end
                        `MODE_VIDEO: begin
                            // Saturate so later video groups stay silent
                            if (grp_q < `VIDEO_TONE_GRPS) begin
                                grp_q <= grp_q + `GRP_ONE;
                            end
                        end
                        `MODE_MEM: begin
                            // Memory groups repeat until power is lost
                            grp_q <= grp_q;
                        end
                        `MODE_UPDATE: begin
                            // Update blinking repeats until done arrives
                            grp_q <= grp_q;
                        end
                        default: grp_q <= grp_q;
                    endcase
                end
            end
        end
    end

    // Registered outputs; reset silences speaker and LED
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            tone_en_q <= 1'b0;
            pitch_q <= `PITCH_STD;
            led_q <= 1'b0;
        end else if (start && (new_mode == `MODE_UPDATE)) begin
            tone_en_q <= 1'b0;
            pitch_q <= `PITCH_STD;
            led_q <= 1'b0;
        end else if (done_acc) begin
            tone_en_q <= 1'b0;
            pitch_q <= `PITCH_STD;
            led_q <= 1'b0;
        end else begin
            tone_en_q <= tone_d;
            pitch_q <= pitch_d;
            led_q <= led_d;
        end
    end

    tone_gen #(
        .CLK_HZ(CLK_HZ)
    ) u_tone (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tone_en(tone_en_q),
        .pitch_sel(pitch_q),
        .wave_q(spk_q)
    );
endmodule
`default_nettype wire

/* File: hdl/beep_consts.vh */
// Purpose: Shared constants for the beep and blink pattern sequencer.
// Assumes: 50 MHz system clock; all pattern timing in 0.25 s steps.
// Notes: Pattern positions count quarter-second steps from zero.
`ifndef BEEP_CONSTS_VH
`define BEEP_CONSTS_VH

`define CLK_HZ 50000000
`define QUARTER_MS 250
`define MS_PER_S 1000

// Tone frequencies in Hz
`define FREQ_STD_HZ 932
`define FREQ_LOW_HZ 1500
`define FREQ_HIGH_HZ 2000

// Pitch select codes
`define PITCH_STD 2'h0
`define PITCH_LOW 2'h1
`define PITCH_HIGH 2'h2

// Sequencer modes
`define MODE_IDLE 3'h0
`define MODE_PROMPT 3'h1
`define MODE_UPDATE 3'h2
`define MODE_VIDEO 3'h3
`define MODE_MEM 3'h4
`define MODE_THERM 3'h5
`define MODE_HALT 3'h6

// Last quarter-step index of each pattern group
`define PROMPT_END 6'h01
`define UPDATE_END 6'h03
`define VIDEO_END 6'h19
`define MEM_END 6'h21
`define THERM_END 6'h1f

// First quarter-step from which bursts stay off for the rest of a group
`define VIDEO_ON_END 6'h10
`define MEM_ON_END 6'h18

// Position bits: 1.0 s phase, 0.5 s phase, 0.25 s phase, tone index
`define BEAT_BIT 2
`define HALF_BIT 1
`define QTR_BIT 0
`define TONE_BIT 2

// Number of audible video groups
`define VIDEO_TONE_GRPS 2'h2
`define GRP_ONE 2'h1

`endif

/* File: hdl/tone_gen.v */
// Purpose: Square-wave tone generator with three selectable pitches.
// Assumes: Enable and pitch select come from the same clock domain.
// Notes: Output is low from the clock after the generator is disabled.
`timescale 1ns/10ps
`default_nettype none
`include "beep_consts.vh"
module tone_gen #(
    parameter integer CLK_HZ = `CLK_HZ
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire tone_en,
    input wire [1:0] pitch_sel,
    output reg wave_q
);
    localparam integer HALF_STD = CLK_HZ / (2 * `FREQ_STD_HZ);
    localparam integer HALF_LOW = CLK_HZ / (2 * `FREQ_LOW_HZ);
    localparam integer HALF_HIGH = CLK_HZ / (2 * `FREQ_HIGH_HZ);

    reg [15:0] cnt_q;
    reg [15:0] limit;

    always @* begin
        case (pitch_sel)
            `PITCH_LOW: limit = HALF_LOW[15:0] - 16'h0001;
            `PITCH_HIGH: limit = HALF_HIGH[15:0] - 16'h0001;
            default: limit = HALF_STD[15:0] - 16'h0001;
        endcase
    end

    // Half-period counter toggles the wave
    always @(posedge clk_sys) begin
        if (sys_rst || !tone_en) begin
            cnt_q <= 16'h0000;
            wave_q <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q <= 16'h0000;
            wave_q <= ~wave_q;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: tb/beep_blink_seq_bench.sv */
// Purpose: Self-checking bench for beep_blink_seq.
// Assumes: Quarter step shortened to 40 cycles.
// Notes: Outputs sampled mid-quarter at falling edges.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; $display("Error %0t: got %h want %h", $time, g, e); end end
module beep_blink_seq_bench;
    localparam int Q = 40;
    // Speaker periods in cycles with CLK_HZ set to 40000 on the bench
    localparam int P_STD = 42, P_LOW = 26, P_HIGH = 20;
    logic clk_sys = 0, sys_rst = 1, ev_prompt = 0, ev_update_start = 0;
    logic ev_update_done = 0, ev_video_err = 0, video_rom_found = 0;
    logic ev_mem_err = 0, ev_thermal = 0;
    wire tone_en_q, spk_q, led_q, shutdown_q;
    wire [1:0] pitch_q;
    int tone_edges, led_blinks, tone_period, mismatches = 0, comparisons = 0;
    int cyc = 0, t0 = 0, b0, e0;
    beep_blink_seq #(.CLK_HZ(40000), .QUARTER_CYC(Q)) beep_blink_seq_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ev_prompt(ev_prompt),
        .ev_update_start(ev_update_start), .ev_update_done(ev_update_done),
        .ev_video_err(ev_video_err), .video_rom_found(video_rom_found),
        .ev_mem_err(ev_mem_err), .ev_thermal(ev_thermal),
        .tone_en_q(tone_en_q), .pitch_q(pitch_q), .spk_q(spk_q),
        .led_q(led_q), .shutdown_q(shutdown_q));
    panel_model panel_model_inst (.clk_sys(clk_sys), .spk_q(spk_q),
        .led_q(led_q), .tone_edges(tone_edges), .led_blinks(led_blinks),
        .tone_period(tone_period));
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // k: 0 prompt, 1 start, 2 done, 3 video, 4 mem, 5 thermal
    task fire(input int k);
        @(negedge clk_sys);
        {ev_thermal, ev_mem_err, ev_video_err, ev_update_done,
            ev_update_start, ev_prompt} = 6'h01 << k;
        @(negedge clk_sys);
        {ev_thermal, ev_mem_err, ev_video_err, ev_update_done,
            ev_update_start, ev_prompt} = 6'h00;
        t0 = cyc;
        b0 = led_blinks;
    endtask
    task exp_q(input int q, input logic t, input logic l);
        while (cyc < t0 + q * Q + Q / 2) @(negedge clk_sys);
        `CHK(tone_en_q, t)
        `CHK(led_q, l)
    endtask
    task t_mem;
        fire(4);
        exp_q(1, 1, 1);
        `CHK(pitch_q, 2'h0)
        exp_q(9, 1, 1);
        exp_q(17, 1, 1);
        exp_q(21, 0, 0);
        exp_q(33, 0, 0);
        `CHK(led_blinks - b0, 3)
        exp_q(35, 1, 1);
    endtask
    task t_prompt;
        fire(0);
        e0 = tone_edges;
        exp_q(0, 1, 1);
        `CHK(pitch_q, 2'h0)
        exp_q(1, 1, 1);
        `CHK(tone_period, P_STD)
        exp_q(4, 0, 1);
        `CHK(tone_edges > e0, 1'b1)
    endtask
    task t_video;
        video_rom_found = 1;
        fire(3);
        exp_q(1, 0, 1);
        video_rom_found = 0;
        fire(3);
        exp_q(1, 1, 1);
        exp_q(5, 0, 0);
        exp_q(9, 1, 1);
        exp_q(13, 0, 0);
        exp_q(27, 1, 1);
        exp_q(53, 0, 1);
        exp_q(57, 0, 0);
    endtask
    task t_therm;
        fire(5);
        for (int q = 0; q < 32; q++) begin
            exp_q(q, 1, ~q[0]);
            `CHK(pitch_q, q[2] ? 2'h1 : 2'h2)
            if (q % 4 == 3) `CHK(tone_period, q[2] ? P_LOW : P_HIGH)
        end
        exp_q(33, 0, 0);
        `CHK(shutdown_q, 1'b1)
        `CHK(led_blinks - b0, 16)
    endtask
    task t_update;
        fire(1);
        exp_q(0, 0, 0);
        exp_q(2, 0, 1);
        exp_q(4, 0, 0);
        exp_q(6, 0, 1);
        fire(2);
        exp_q(3, 0, 0);
        `CHK(shutdown_q, 1'b1)
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        `CHK(led_q, 1'b0)
        sys_rst = 0;
        t_mem();
        t_prompt();
        t_video();
        t_therm();
        t_update();
        sys_rst = 1;
        repeat (2) @(negedge clk_sys);
        `CHK(shutdown_q, 1'b0)
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: tb/panel_model.sv */
// Purpose: Speaker and power LED load that counts what it sees.
// Assumes: Outputs sampled on clk_sys.
// Notes: Counts rising edges only.
`timescale 1ns/10ps
`default_nettype none
module panel_model (
    input wire logic clk_sys,
    input wire logic spk_q,
    input wire logic led_q,
    output int tone_edges,
    output int led_blinks,
    output int tone_period
);
    logic spk_l = 0, led_l = 0;
    int since = 0;
    initial tone_edges = 0;
    initial led_blinks = 0;
    initial tone_period = 0;
    // Period is the cycle count between the last two speaker rises
    always @(posedge clk_sys) begin
        if (spk_q && !spk_l) begin
            tone_edges <= tone_edges + 1;
            tone_period <= since + 1;
            since <= 0;
        end else begin
            since <= since + 1;
        end
        if (led_q && !led_l) led_blinks <= led_blinks + 1;
        spk_l <= spk_q;
        led_l <= led_q;
    end
endmodule
`default_nettype wire

/* File: tb/seq_checker_properties.sv */
// Purpose: Port assertions for beep_blink_seq.
// Assumes: Bench events are isolated one-cycle pulses.
// Notes: One clock domain, reset disables all but one.
`timescale 1ns/10ps
`default_nettype none
module seq_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ev_prompt,
    input wire logic ev_update_start,
    input wire logic ev_video_err,
    input wire logic video_rom_found,
    input wire logic ev_mem_err,
    input wire logic ev_thermal,
    input wire logic tone_en_q,
    input wire logic [1:0] pitch_q,
    input wire logic spk_q,
    input wire logic led_q,
    input wire logic shutdown_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    reset_quiet_a: assert property (disable iff (1'b0)
        sys_rst |=> !tone_en_q && !led_q && !shutdown_q)
        else $error("outputs live after reset");
    shutdown_hold_a: assert property (shutdown_q |=> shutdown_q)
        else $error("shutdown request dropped");
    spk_quiet_a: assert property (!tone_en_q [*2] |-> !spk_q)
        else $error("speaker moves with tone off");
    update_off_a: assert property (ev_update_start |=>
        (!tone_en_q && !led_q) [*8]) else $error("update not dark");
    prompt_tone_a: assert property (ev_prompt |-> ##3
        (tone_en_q && pitch_q == 2'h0 && $stable(led_q)) [*6])
        else $error("prompt tone wrong");
    mem_start_a: assert property (ev_mem_err |-> ##3
        tone_en_q && led_q && pitch_q == 2'h0) else $error("mem start");
    video_start_a: assert property (ev_video_err && !video_rom_found
        |-> ##3 tone_en_q && led_q && pitch_q == 2'h0)
        else $error("video start");
    therm_start_a: assert property (ev_thermal |-> ##3
        (tone_en_q && pitch_q == 2'h2 && led_q) [*4])
        else $error("thermal start");
    cover property ($rose(shutdown_q));
    cover property (ev_mem_err);
    cover property (ev_update_start);
endmodule
bind beep_blink_seq seq_checker seq_checker_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .ev_prompt(ev_prompt),
    .ev_update_start(ev_update_start), .ev_video_err(ev_video_err),
    .video_rom_found(video_rom_found), .ev_mem_err(ev_mem_err),
    .ev_thermal(ev_thermal), .tone_en_q(tone_en_q), .pitch_q(pitch_q),
    .spk_q(spk_q), .led_q(led_q), .shutdown_q(shutdown_q));
`default_nettype wire
